/* logic/power_mgmt_cfg.svh */
// Register offsets, field positions and reset values for the power management registers
`ifndef POWER_MGMT_CFG_SVH
`define POWER_MGMT_CFG_SVH
`define ADDR_POWER_CONTROL 8'hC5
`define ADDR_POWER_IRQ_ENABLE 8'hEC
`define ADDR_EVENT_FLAGS 8'hF8
`define ADDR_WRITE_KEY 8'hC1
`define ADDR_SCRATCH_ONE 8'hFB
`define ADDR_SCRATCH_TWO 8'hFC
`define ADDR_SCRATCH_THREE 8'hFD
`define ADDR_SCRATCH_FOUR 8'hFE
`define WRITE_KEY_VALUE 8'hA7
`define POWER_CONTROL_RESET 8'h82
`define POWER_CONTROL_MASK 8'hD7
`define IRQ_ENABLE_RESET 8'h00
`define IRQ_ENABLE_MASK 8'hAF
`define FLAG_MASK 8'hAF
`define SCRATCH_RESET 8'h00
`define FLAG_RESET 8'h00
`define POWER_CONTROL_FORCED 8'h80
`define DIVIDER_RESET 3'h2
`define BIT_SUPPLY_RESTORED 7
`define BIT_SAG 5
`define BIT_ANALOG_INPUT 3
`define BIT_BATTERY_MON 2
`define BIT_SWITCHOVER 1
`define BIT_DC_INPUT 0
`define BIT_METERING_SHUTDOWN 6
`define BIT_CORE_SHUTDOWN 4
`define DIV_MSB 2
`define DIV_LSB 0
`endif

/* logic/power_mgmt_pkg.sv */
// Types shared by the power management register group
package power_mgmt_pkg;
   typedef logic [7:0] sfr_byte_type;
   typedef logic [2:0] clock_div_type;
endpackage : power_mgmt_pkg

/* logic/power_mgmt_control_regs.sv */
// Power management control registers: interrupt enables, flags, scratch, power control
`timescale 1ns/1ps
`default_nettype none
`include "power_mgmt_cfg.svh"

// Function
// RULE1: Enable bit 7 lets the supply restored flag raise the shared interrupt.
// RULE2: Enable bit 5 lets the sag flag raise the shared interrupt.
// RULE3: Enable bit 3 lets the analog input monitor flag raise the interrupt.
// RULE4: Enable bit 2 lets the battery monitor flag raise the interrupt.
// RULE5: Enable bit 1 lets the switchover flag raise the interrupt.
// RULE6: Enable bit 0 lets the dc input monitor flag raise the interrupt.
// RULE7: Software writes zero to reserved enable bit 4.
// RULE8: Four read-write scratch bytes at 0xFB to 0xFE, kept in every mode.
// RULE9: Scratch bytes clear only on total supply loss, not on other resets.
// RULE10: Power control bit 6 switches off the metering modulators and processing.
// RULE11: Power control bit 4 in battery mode stops the core, entering sleep.
// RULE12: Bits 2 to 0 divide 4.096 MHz by two to the code; reset 010.
// RULE13: Software keeps power control bit 5 at zero.
// RULE14: A power control write is taken only right after key write 0xA7.
// RULE15: Event flags set on their events regardless of enables.
// RULE16: Flags stay set until software writes zero to them.
// RULE17: Interrupt reaches the core only with the master enable set.
// RULE18: Request is the OR of each flag ANDed with its enable.
// RULE19: Enables reset to zero; power control bit 7 reads one after reset.
module power_mgmt_control_regs
   import power_mgmt_pkg::*;
(
   input wire logic ref_clk, // 125 MHz clock
   input wire logic rst_b, // Async reset for ordinary resets
   input wire logic supply_loss_rst_b, // Async reset only on total supply loss
   input wire logic [7:0] sfr_addr, // Register address
   input wire logic sfr_wr, // Write strobe
   input wire logic [7:0] sfr_wdata, // Write data
   input wire logic sfr_rd, // Read strobe
   output logic [7:0] sfr_rdata, // Read data, registered
   input wire logic [7:0] event_pulse, // Event pulses, flag layout
   input wire logic battery_mode, // Device in battery mode
   input wire logic power_irq_master_enable, // Master enable from core
   output logic power_management_interrupt, // Interrupt to core
   output logic metering_shutdown, // Metering circuitry off
   output logic core_shutdown, // Core stop request
   output logic [2:0] core_clock_divider // Core clock divider code
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   sfr_byte_type power_control_reg;
   sfr_byte_type power_irq_enable_reg;
   sfr_byte_type flags_reg;
   sfr_byte_type flags_next;
   sfr_byte_type scratch_reg [0:3];
   logic key_armed_reg;
   sfr_byte_type rdata_next;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Each strobe is a named wire so the processes stay short
   wire logic wr_key = sfr_wr && (sfr_addr == `ADDR_WRITE_KEY);
   wire logic wr_pc = sfr_wr && (sfr_addr == `ADDR_POWER_CONTROL) && key_armed_reg; // RULE14
   wire logic wr_en = sfr_wr && (sfr_addr == `ADDR_POWER_IRQ_ENABLE);
   wire logic wr_flag = sfr_wr && (sfr_addr == `ADDR_EVENT_FLAGS);
   wire logic sc_hit = (sfr_addr >= `ADDR_SCRATCH_ONE)
      && (sfr_addr <= `ADDR_SCRATCH_FOUR); // RULE8
   wire logic [1:0] sc_idx = 2'(sfr_addr - `ADDR_SCRATCH_ONE);
   wire sfr_byte_type pending = flags_reg & power_irq_enable_reg; // RULE18
   wire logic irq_req = pending[`BIT_SUPPLY_RESTORED] // RULE1
      | pending[`BIT_SAG] // RULE2
      | pending[`BIT_ANALOG_INPUT] // RULE3
      | pending[`BIT_BATTERY_MON] // RULE4
      | pending[`BIT_SWITCHOVER] // RULE5
      | pending[`BIT_DC_INPUT]; // RULE6

   // Set wins over a software clear in the same cycle
   always_comb
   begin
      flags_next = flags_reg;
      if (wr_flag)
      begin
         flags_next = flags_reg & sfr_wdata; // RULE16
      end
      flags_next = (flags_next | event_pulse) & `FLAG_MASK; // RULE15
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_next = 8'h00;
      if (sfr_addr == `ADDR_POWER_CONTROL)
      begin
         rdata_next = power_control_reg;
      end
      else if (sfr_addr == `ADDR_POWER_IRQ_ENABLE)
      begin
         rdata_next = power_irq_enable_reg;
      end
      else if (sfr_addr == `ADDR_EVENT_FLAGS)
      begin
         rdata_next = flags_reg;
      end
      else if (sc_hit)
      begin
         rdata_next = scratch_reg[sc_idx];
      end
   end

   // ----------------------------------------
   // Registers on ordinary reset
   // ----------------------------------------
   // Key arms only for the very next write; any other write disarms it
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         key_armed_reg <= 1'b0;
         power_control_reg <= `POWER_CONTROL_RESET; // RULE19
         power_irq_enable_reg <= `IRQ_ENABLE_RESET; // RULE19
         flags_reg <= `FLAG_RESET;
         sfr_rdata <= 8'h00;
      end
      else
      begin
         if (sfr_wr)
         begin
            key_armed_reg <= wr_key && (sfr_wdata == `WRITE_KEY_VALUE); // RULE14
         end
         if (wr_pc)
         begin
            // Reserved bits forced: bit 7 one, bits 5 and 3 zero (RULE13 on software)
            power_control_reg <= (sfr_wdata & `POWER_CONTROL_MASK) | `POWER_CONTROL_FORCED;
         end
         if (wr_en)
         begin
            power_irq_enable_reg <= sfr_wdata & `IRQ_ENABLE_MASK; // RULE7
         end
         flags_reg <= flags_next;
         if (sfr_rd)
         begin
            sfr_rdata <= rdata_next;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Registered so the core sees clean levels
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         power_management_interrupt <= 1'b0;
         metering_shutdown <= 1'b0;
         core_shutdown <= 1'b0;
         core_clock_divider <= `DIVIDER_RESET;
      end
      else
      begin
         power_management_interrupt <= irq_req && power_irq_master_enable; // RULE17
         metering_shutdown <= power_control_reg[`BIT_METERING_SHUTDOWN]; // RULE10
         core_shutdown <= power_control_reg[`BIT_CORE_SHUTDOWN] && battery_mode; // RULE11
         core_clock_divider <= power_control_reg[`DIV_MSB:`DIV_LSB]; // RULE12
      end
   end

   // ----------------------------------------
   // Retained scratch
   // ----------------------------------------
   // Only total supply loss clears these; ordinary resets leave them alone
   always_ff @(posedge ref_clk or negedge supply_loss_rst_b)
   begin
      if (!supply_loss_rst_b)
      begin
         for (int i = 0; i < 4; i++)
         begin
            scratch_reg[i] <= `SCRATCH_RESET; // RULE9
         end
      end
      else if (sfr_wr && sc_hit)
      begin
         scratch_reg[sc_idx] <= sfr_wdata; // RULE8
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_irq_from_pending: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE18
      $past(irq_req) && $past(power_irq_master_enable) |-> power_management_interrupt)
      else $error("interrupt missing");
   a_irq_needs_master: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE17
      power_management_interrupt |-> $past(power_irq_master_enable))
      else $error("interrupt without master enable");
   a_restored_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE1
      (flags_reg == `POWER_CONTROL_FORCED) && !power_irq_enable_reg[`BIT_SUPPLY_RESTORED]
      |=> !power_management_interrupt)
      else $error("disabled flag raised interrupt");
   a_sag_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE2
      flags_reg[`BIT_SAG] && power_irq_enable_reg[`BIT_SAG] && power_irq_master_enable
      |=> power_management_interrupt)
      else $error("sag interrupt missing");
   a_flag_sets: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE15
      event_pulse[`BIT_SWITCHOVER] |=> flags_reg[`BIT_SWITCHOVER])
      else $error("flag not set on event");
   a_flag_holds: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE16
      flags_reg[`BIT_DC_INPUT] && !wr_flag |=> flags_reg[`BIT_DC_INPUT])
      else $error("flag dropped without clear");
   a_key_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE14
      sfr_wr && (sfr_addr == `ADDR_POWER_CONTROL) && !key_armed_reg
      |=> $stable(power_control_reg))
      else $error("unkeyed power control write");
   a_core_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE11
      core_shutdown |-> $past(battery_mode))
      else $error("core off outside battery mode");
   a_divider_out: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
      ##1 core_clock_divider == $past(power_control_reg[`DIV_MSB:`DIV_LSB]))
      else $error("divider mismatch");
   a_scratch_keep: assert property (@(posedge ref_clk) disable iff (!supply_loss_rst_b) // RULE9
      !sfr_wr ##1 !rst_b |-> $stable(scratch_reg[0]))
      else $error("scratch lost on ordinary reset");
   c_irq_raised: cover property (@(posedge ref_clk) disable iff (!rst_b)
      power_management_interrupt);
   c_keyed_write: cover property (@(posedge ref_clk) disable iff (!rst_b) wr_pc);
   c_set_clear_race: cover property (@(posedge ref_clk) disable iff (!rst_b)
      wr_flag && (event_pulse != 8'h00));

endmodule : power_mgmt_control_regs
`default_nettype wire

/* tb/power_mgmt_control_regs_tb.sv */
// Self-checking bench for the power management register group
`timescale 1ns/1ps
`default_nettype none
`include "power_mgmt_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module power_mgmt_control_regs_tb
   import power_mgmt_pkg::*;
;
   // ----------------------------------------
   // Stimulus signals and counters
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic supply_loss_rst_b = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_rd = 1'b0;
   logic [7:0] event_pulse = 8'h00;
   logic battery_mode = 1'b0;
   logic power_irq_master_enable = 1'b0;
   sfr_byte_type sfr_rdata;
   logic power_management_interrupt;
   logic metering_shutdown;
   logic core_shutdown;
   clock_div_type core_clock_divider;
   int errors = 0;
   int n_checks = 0;
   int src [6] = '{7, 5, 3, 2, 1, 0};
   always #4 ref_clk = ~ref_clk;
   power_mgmt_control_regs i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .supply_loss_rst_b(supply_loss_rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .event_pulse(event_pulse), .battery_mode(battery_mode),
      .power_irq_master_enable(power_irq_master_enable),
      .power_management_interrupt(power_management_interrupt),
      .metering_shutdown(metering_shutdown), .core_shutdown(core_shutdown),
      .core_clock_divider(core_clock_divider));
   // ----------------------------------------
   // Access tasks, each leaves a spare cycle so strobes never retoggle in one step
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick(1);
      sfr_rd = 1'b0;
      `CHK(sfr_rdata, e)
      tick(1);
   endtask : rd
   task automatic pulse(input logic [7:0] p);
      event_pulse = p;
      tick(1);
      event_pulse = 8'h00;
      tick(1);
   endtask : pulse
   task automatic conclude;
      if (errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Watchdog, far beyond the about 165 cycles the tests need
   // ----------------------------------------
   initial
   begin
      #40000;
      errors++;
      conclude();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      tick(5);
      rst_b = 1'b1;
      supply_loss_rst_b = 1'b1;
      tick(1);
      rd(`ADDR_POWER_CONTROL, 8'h82);
      rd(`ADDR_POWER_IRQ_ENABLE, 8'h00);
      `CHK(core_clock_divider, 3'h2)
      rd(8'h80, 8'h00);
      for (int i = 0; i < 4; i++) rd(8'(`ADDR_SCRATCH_ONE + i), 8'h00);
      // Scratch survives an ordinary reset and a mode change, clears on supply loss
      for (int i = 0; i < 4; i++) wr(8'(`ADDR_SCRATCH_ONE + i), 8'(8'h5A + 8'h31 * i));
      battery_mode = 1'b1;
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      tick(1);
      for (int i = 0; i < 4; i++) rd(8'(`ADDR_SCRATCH_ONE + i), 8'(8'h5A + 8'h31 * i));
      supply_loss_rst_b = 1'b0;
      tick(1);
      supply_loss_rst_b = 1'b1;
      tick(1);
      rd(`ADDR_SCRATCH_FOUR, 8'h00);
      // Flags latch with enables off; writing one keeps them
      pulse(8'hFF);
      rd(`ADDR_EVENT_FLAGS, 8'hAF);
      `CHK(power_management_interrupt, 1'b0)
      wr(`ADDR_EVENT_FLAGS, 8'hFF);
      rd(`ADDR_EVENT_FLAGS, 8'hAF);
      // Clear with a new event in the same cycle: the event must win
      sfr_addr = `ADDR_EVENT_FLAGS;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b1;
      event_pulse = 8'h02;
      tick(1);
      sfr_wr = 1'b0;
      event_pulse = 8'h00;
      tick(1);
      rd(`ADDR_EVENT_FLAGS, 8'h02);
      // Software keeps reserved bit 4 clear
      wr(`ADDR_POWER_IRQ_ENABLE, 8'hEF);
      rd(`ADDR_POWER_IRQ_ENABLE, 8'hAF);
      `CHK(power_management_interrupt, 1'b0)
      power_irq_master_enable = 1'b1;
      tick(2);
      `CHK(power_management_interrupt, 1'b1)
      // Each source alone raises the request, its enable gates it
      foreach (src[k])
      begin
         wr(`ADDR_EVENT_FLAGS, 8'h00);
         wr(`ADDR_POWER_IRQ_ENABLE, 8'(1 << src[k]));
         `CHK(power_management_interrupt, 1'b0)
         pulse(8'(1 << src[k]));
         `CHK(power_management_interrupt, 1'b1)
         wr(`ADDR_POWER_IRQ_ENABLE, 8'(~(1 << src[k]) & 8'hEF));
         `CHK(power_management_interrupt, 1'b0)
      end
      // Power control needs the key right before it
      wr(`ADDR_POWER_CONTROL, 8'h40);
      rd(`ADDR_POWER_CONTROL, 8'h82);
      wr(`ADDR_WRITE_KEY, `WRITE_KEY_VALUE);
      wr(`ADDR_SCRATCH_ONE, 8'h11);
      wr(`ADDR_POWER_CONTROL, 8'h40);
      rd(`ADDR_POWER_CONTROL, 8'h82);
      wr(`ADDR_WRITE_KEY, `WRITE_KEY_VALUE);
      wr(`ADDR_POWER_CONTROL, 8'h40);
      `CHK(metering_shutdown, 1'b1)
      rd(`ADDR_POWER_CONTROL, 8'hC0);
      wr(`ADDR_WRITE_KEY, `WRITE_KEY_VALUE);
      wr(`ADDR_POWER_CONTROL, 8'h17);
      `CHK({metering_shutdown, core_shutdown}, 2'h1)
      battery_mode = 1'b0;
      tick(2);
      `CHK(core_shutdown, 1'b0)
      for (int c = 0; c < 8; c++)
      begin
         wr(`ADDR_WRITE_KEY, `WRITE_KEY_VALUE);
         wr(`ADDR_POWER_CONTROL, 8'(c));
         `CHK(core_clock_divider, 3'(c))
      end
      conclude();
   end
endmodule : power_mgmt_control_regs_tb
`default_nettype wire
